// file: design/remap_cfg.svh
// constants for the upper remappable pin output selector block
`ifndef REMAP_CFG_SVH
`define REMAP_CFG_SVH

// axi4-lite widths
`define AXI_AW 32
`define AXI_DW 32
`define AXI_SW 4

// selector field layout inside one 16-bit register
`define SEL_W 5
`define SEL_LO_LSB 0
`define SEL_HI_LSB 8
`define SEL_RESET 5'h00
`define SEL_NONE 5'h00
`define REG_W 16
`define LO_LANE 0
`define HI_LANE 1

// sizes
`define REG_COUNT 5
`define PIN_COUNT 10
`define PERIPH_COUNT 32
`define IDX_W 3

// register byte offsets
`define OFS_SEL_16_17 32'h0000_0000
`define OFS_SEL_18_19 32'h0000_0004
`define OFS_SEL_20_21 32'h0000_0008
`define OFS_SEL_22_23 32'h0000_000c
`define OFS_SEL_24_25 32'h0000_0010

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// file: design/remap_pkg.sv
// types shared by the remappable pin output selector block
package remap_pkg;

`include "remap_cfg.svh"

    typedef logic [`SEL_W-1:0] sel_t;

    typedef struct packed {
        logic awvalid;
        logic [`AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [`AXI_DW-1:0] wdata;
        logic [`AXI_SW-1:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`AXI_AW-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [`AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef struct packed {
        sel_t hi;
        sel_t lo;
    } pair_state_t;

    typedef struct packed {
        logic drive;
        logic remapped;
    } pin_state_t;

    typedef struct packed {
        logic aw_held;
        logic [`AXI_AW-1:0] aw_addr;
        logic w_held;
        logic [`AXI_DW-1:0] w_data;
        logic [`AXI_SW-1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [`AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } slave_state_t;

endpackage

// file: design/pin_pair_reg.sv
// one selector register holding the selectors of two remappable pins
`timescale 1ns/10ps
`include "remap_cfg.svh"
module pin_pair_reg
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [`REG_W-1:0] wr_data,
    input wire logic [1:0] wr_strb,
    output remap_pkg::sel_t sel_lo,
    output remap_pkg::sel_t sel_hi,
    output logic [`REG_W-1:0] readback
);
    import remap_pkg::*;

    pair_state_t s;
    pair_state_t next_s;

    always_comb
    begin
        next_s = s;
        // absent registers in the small package swallow every write
        if (wr_en && !SMALL_PACKAGE)
        begin
            if (wr_strb[`LO_LANE])
            begin
                next_s.lo = wr_data[`SEL_LO_LSB +: `SEL_W];
            end
            if (wr_strb[`HI_LANE])
            begin
                next_s.hi = wr_data[`SEL_HI_LSB +: `SEL_W];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '{hi: `SEL_RESET, lo: `SEL_RESET};
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    assign sel_lo = s.lo;
    assign sel_hi = s.hi;

    // unimplemented positions stay zero on read
    always_comb
    begin
        readback = '0;
        if (!SMALL_PACKAGE)
        begin
            readback[`SEL_LO_LSB +: `SEL_W] = s.lo;
            readback[`SEL_HI_LSB +: `SEL_W] = s.hi;
        end
    end

endmodule

// file: design/pin_out_mux.sv
// routes the selected peripheral output onto one remappable pin
`timescale 1ns/10ps
`include "remap_cfg.svh"
module pin_out_mux
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [`PERIPH_COUNT-1:0] periph_out,
    input remap_pkg::sel_t sel,
    output logic pin_drive,
    output logic pin_remapped
);
    import remap_pkg::*;

    pin_state_t s;
    pin_state_t next_s;

    always_comb
    begin
        next_s.remapped = (sel != `SEL_NONE);
        // selector zero is no source: the port logic keeps the pin
        next_s.drive = (sel != `SEL_NONE) ? periph_out[sel] : 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '{drive: 1'b0, remapped: 1'b0};
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    assign pin_drive = s.drive;
    assign pin_remapped = s.remapped;

endmodule

// file: design/remap_output_select_upper.sv
// output selector registers and routing for remappable pins 16 to 25
`timescale 1ns/10ps
`include "remap_cfg.svh"

module remap_output_select_upper
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input remap_pkg::axil_req_t bus_in,
    output remap_pkg::axil_rsp_t bus_out,
    input wire logic [`PERIPH_COUNT-1:0] periph_out,
    output logic [`PIN_COUNT-1:0] pin_drive,
    output logic [`PIN_COUNT-1:0] pin_remapped
);
    import remap_pkg::*;

    // ************************************************************
    // address decode
    // ************************************************************

    // returns {hit, index}; unaligned or unknown addresses miss
    function automatic logic [`IDX_W:0] decode(
        input logic [`AXI_AW-1:0] addr
    );
        logic [`IDX_W:0] r;
        r = '0;
        case (addr)
            `OFS_SEL_16_17: r = {1'b1, 3'h0};
            `OFS_SEL_18_19: r = {1'b1, 3'h1};
            `OFS_SEL_20_21: r = {1'b1, 3'h2};
            `OFS_SEL_22_23: r = {1'b1, 3'h3};
            `OFS_SEL_24_25: r = {1'b1, 3'h4};
            default: r = '0;
        endcase
        return r;
    endfunction

    slave_state_t s;
    slave_state_t next_s;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic aw_have;
    logic w_have;
    logic wr_go;
    logic [`AXI_AW-1:0] wr_addr;
    logic [`AXI_DW-1:0] wr_word;
    logic [`AXI_SW-1:0] wr_strb_full;
    logic [`IDX_W:0] wr_dec;
    logic [`IDX_W:0] rd_dec;
    logic [`REG_W-1:0] wr_data16;
    logic [1:0] wr_strb2;
    logic [`REG_COUNT-1:0] wr_hit;
    logic [`REG_W-1:0] readback [`REG_COUNT];
    sel_t sel [`PIN_COUNT];

    // ************************************************************
    // axi4-lite handshakes
    // ************************************************************

    // readies drop while ce is low so no transfer slips past a frozen state
    always_comb
    begin
        bus_out.awready = ce && !s.aw_held && !s.bvalid;
        bus_out.wready = ce && !s.w_held && !s.bvalid;
        bus_out.bvalid = s.bvalid;
        bus_out.bresp = s.bresp;
        bus_out.arready = ce && !s.rvalid;
        bus_out.rvalid = s.rvalid;
        bus_out.rdata = s.rdata;
        bus_out.rresp = s.rresp;
    end

    assign aw_fire = bus_in.awvalid && bus_out.awready;
    assign w_fire = bus_in.wvalid && bus_out.wready;
    assign ar_fire = bus_in.arvalid && bus_out.arready;
    assign aw_have = s.aw_held || aw_fire;
    assign w_have = s.w_held || w_fire;
    // address and data may arrive in either order; act once both are in
    assign wr_go = ce && aw_have && w_have;
    assign wr_addr = s.aw_held ? s.aw_addr : bus_in.awaddr;
    assign wr_word = s.w_held ? s.w_data : bus_in.wdata;
    assign wr_strb_full = s.w_held ? s.w_strb : bus_in.wstrb;
    assign wr_dec = decode(wr_addr);
    assign rd_dec = decode(bus_in.araddr);
    assign wr_data16 = wr_word[`REG_W-1:0];
    // upper two byte lanes land on bits that do not exist
    assign wr_strb2 = wr_strb_full[1:0];

    always_comb
    begin
        for (int i = 0; i < `REG_COUNT; i++)
        begin
            wr_hit[i] = wr_go && wr_dec[`IDX_W]
                && (wr_dec[`IDX_W-1:0] == i[`IDX_W-1:0]);
        end
    end

    // ************************************************************
    // slave state
    // ************************************************************

    always_comb
    begin
        next_s = s;
        if (s.bvalid && bus_in.bready)
        begin
            next_s.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_dec[`IDX_W] ? `RESP_OKAY : `RESP_DECERR;
        end
        else
        begin
            if (aw_fire)
            begin
                next_s.aw_held = 1'b1;
                next_s.aw_addr = bus_in.awaddr;
            end
            if (w_fire)
            begin
                next_s.w_held = 1'b1;
                next_s.w_data = bus_in.wdata;
                next_s.w_strb = bus_in.wstrb;
            end
        end
        if (s.rvalid && bus_in.rready)
        begin
            next_s.rvalid = 1'b0;
        end
        if (ar_fire)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = '0;
            next_s.rresp = `RESP_DECERR;
            if (rd_dec[`IDX_W])
            begin
                // absent registers still answer okay, with zero data
                next_s.rdata[`REG_W-1:0] = readback[rd_dec[`IDX_W-1:0]];
                next_s.rresp = `RESP_OKAY;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    // ************************************************************
    // selector registers and pin routing
    // ************************************************************

    genvar g;
    generate
        for (g = 0; g < `REG_COUNT; g++)
        begin : g_reg
            // pair g holds pins 16+2g (low field) and 17+2g (high field)
            pin_pair_reg #(
                .SMALL_PACKAGE(SMALL_PACKAGE)
            ) u_pair (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .wr_en(wr_hit[g]),
                .wr_data(wr_data16),
                .wr_strb(wr_strb2),
                .sel_lo(sel[2*g]),
                .sel_hi(sel[2*g+1]),
                .readback(readback[g])
            );
        end
        for (g = 0; g < `PIN_COUNT; g++)
        begin : g_pin
            pin_out_mux u_mux (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .periph_out(periph_out),
                .sel(sel[g]),
                .pin_drive(pin_drive[g]),
                .pin_remapped(pin_remapped[g])
            );
        end
    endgenerate

    // ************************************************************
    // assertions
    // ************************************************************

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_field_map(int unsigned idx);
        (wr_hit[idx] && wr_strb2 == 2'h3 && !SMALL_PACKAGE)
        |=> (sel[2*idx] == $past(wr_data16[`SEL_LO_LSB +: `SEL_W]))
            && (sel[2*idx+1] == $past(wr_data16[`SEL_HI_LSB +: `SEL_W]));
    endproperty

    a_route_pin_16: assert property (
        (ce && sel[0] != `SEL_NONE)
        |=> pin_drive[0] == $past(periph_out[sel[0]]) && pin_remapped[0])
        else $error("pin 16 does not follow its selected output");

    a_map_pins_16_17: assert property (p_field_map(0))
        else $error("pins 16/17 selector fields misplaced");

    a_map_pins_18_19: assert property (p_field_map(1))
        else $error("pins 18/19 selector fields misplaced");

    a_map_pins_20_21: assert property (p_field_map(2))
        else $error("pins 20/21 selector fields misplaced");

    a_map_pins_22_23: assert property (p_field_map(3))
        else $error("pins 22/23 selector fields misplaced");

    a_map_pins_24_25: assert property (p_field_map(4))
        else $error("pins 24/25 selector fields misplaced");

    a_unimpl_bits_zero: assert property (
        s.rvalid |-> s.rdata[`AXI_DW-1:`REG_W] == '0
            && s.rdata[`REG_W-1:`SEL_HI_LSB+`SEL_W] == '0
            && s.rdata[`SEL_HI_LSB-1:`SEL_LO_LSB+`SEL_W] == '0)
        else $error("unimplemented register bits read nonzero");

    a_small_pkg_zero: assert property (
        (SMALL_PACKAGE && s.rvalid) |-> s.rdata == '0 && sel[0] == '0)
        else $error("absent register returned data in small package");

    a_reset_clears_sel: assert property (
        $rose(aresetn) |-> sel[0] == '0 && sel[9] == '0
            && pin_remapped == '0 ##1 pin_remapped == '0)
        else $error("selectors not cleared by reset");

    a_empty_strobe_noop: assert property (
        (wr_go && wr_strb2 == 2'h0) |=> $stable(sel[0]) && $stable(sel[9]))
        else $error("write without strobes changed a selector");

    a_zero_sel_idle: assert property (
        (ce && sel[1] == `SEL_NONE) |=> !pin_remapped[1] && !pin_drive[1])
        else $error("pin 17 driven with selector zero");

    a_write_answer: assert property (
        wr_go |=> s.bvalid)
        else $error("write response missing one cycle after write");

    a_route_pin_25: assert property (
        (ce && sel[9] != `SEL_NONE)
        |=> pin_drive[9] == $past(periph_out[sel[9]]) && pin_remapped[9])
        else $error("pin 25 does not follow its selected output");

    a_unmapped_noop: assert property (
        (wr_go && !wr_dec[`IDX_W]) |=> $stable(sel[0]) && $stable(sel[9]))
        else $error("write to an unmapped place changed a selector");

    a_small_no_route: assert property (
        SMALL_PACKAGE |-> pin_remapped == '0 && pin_drive == '0)
        else $error("small package drove a pin from an absent selector");

    a_read_answer: assert property (
        ar_fire |=> s.rvalid)
        else $error("read data missing one cycle after read address");

    // a frozen block must not let the pins follow the peripherals
    a_ce_freeze: assert property (
        !ce |=> $stable(pin_drive) && $stable(pin_remapped) && $stable(s))
        else $error("state moved while the clock enable was low");

    c_write_done: cover property (s.bvalid && bus_in.bready);
    c_read_done: cover property (s.rvalid && bus_in.rready);
    c_pin_routed: cover property ($rose(pin_remapped[0]));
    c_unmapped: cover property (wr_go && !wr_dec[`IDX_W]);
    c_ce_hold: cover property (!ce ##1 ce);

endmodule

// file: dv/tb_remap_output_select_upper.sv
// self-checking bench for the upper remappable pin output selectors
`timescale 1ns/10ps
`include "remap_cfg.svh"
module tb_remap_output_select_upper;
import remap_pkg::*;
// ************************************************************
// signals and instances
// ************************************************************
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic ce = 1'b1;
axil_req_t req = '0;
axil_rsp_t rsp;
axil_rsp_t rsp_s;
logic [31:0] periph_out = 32'h0;
logic [9:0] pin_drive;
logic [9:0] pin_remapped;
logic [9:0] pin_drive_s;
logic [9:0] pin_remapped_s;
int miscompares = 0;
int cmp_count = 0;
integer seed = 32'h9386b258;
logic [4:0] sel [10];
always #10 aclk = ~aclk;
remap_output_select_upper dut
(
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .bus_in(req), .bus_out(rsp),
    .periph_out(periph_out), .pin_drive(pin_drive),
    .pin_remapped(pin_remapped)
);
// the 28-pin variant sees the same bus traffic in lock step
remap_output_select_upper #(.SMALL_PACKAGE(1'b1)) dut_small
(
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .bus_in(req),
    .bus_out(rsp_s), .periph_out(periph_out), .pin_drive(pin_drive_s),
    .pin_remapped(pin_remapped_s)
);
// ************************************************************
// checking and bus tasks
// ************************************************************
task automatic check(input string name, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
        miscompares++;
        $display("ERROR %s expected %h seen %h", name, exp, got);
    end
endtask
function automatic logic [31:0] exp_reg(input int i);
    return {16'h0, 3'h0, sel[2*i+1], 3'h0, sel[2*i]};
endfunction
// ready is sampled mid-cycle where it has settled, so the transfer
// edge is the next rising edge
task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
                  output logic [1:0] r, rs);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    while (!(aw && w))
    begin
        @(negedge aclk);
        aw = aw | rsp.awready;
        w = w | rsp.wready;
        @(posedge aclk);
        if (aw) req.awvalid <= 1'b0;
        if (w) req.wvalid <= 1'b0;
    end
    // the wait for the answer has no limit of its own; only the watchdog bounds it
    do
    begin
        @(negedge aclk);
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    rs = rsp_s.bresp;
    @(posedge aclk);
    req.bready <= 1'b0;
endtask
task automatic rd(input logic [31:0] a, output logic [31:0] d, ds,
                  output logic [1:0] r, rs);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
        @(negedge aclk);
    end while (rsp.arready !== 1'b1);
    @(posedge aclk);
    req.arvalid <= 1'b0;
    do
    begin
        @(negedge aclk);
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    ds = rsp_s.rdata;
    r = rsp.rresp;
    rs = rsp_s.rresp;
    @(posedge aclk);
    req.rready <= 1'b0;
endtask
task automatic pin_check();
    logic [9:0] ed;
    logic [9:0] er;
    @(posedge aclk);
    periph_out <= $random(seed);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    for (int k = 0; k < 10; k++)
    begin
        er[k] = (sel[k] != 5'h00);
        ed[k] = er[k] & periph_out[sel[k]];
    end
    check("pin_drive", {22'h0, ed}, {22'h0, pin_drive});
    check("pin_remapped", {22'h0, er}, {22'h0, pin_remapped});
    check("small_drive", 32'h0, {22'h0, pin_drive_s});
    check("small_remap", 32'h0, {22'h0, pin_remapped_s});
endtask
task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
// ************************************************************
// main sequence
// ************************************************************
initial
begin
    #400000;
    miscompares++;
    print_verdict();
end
initial
begin
    logic [31:0] d;
    logic [31:0] ds;
    logic [31:0] wd;
    logic [3:0] s;
    logic [1:0] r;
    logic [1:0] rs;
    logic [9:0] pd;
    int i;
    foreach (sel[k]) sel[k] = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
        rd(32'(i * 4), d, ds, r, rs);
        check("reset_value", 32'h0, d);
        check("small_read", 32'h0, ds);
    end
    pin_check();
    for (int it = 0; it < 40; it++)
    begin
        i = $unsigned($random(seed)) % 5;
        wd = $random(seed);
        s = $random(seed);
        if (it < 5)
        begin
            i = it;
            wd = 32'hffff_ffff;
            s = 4'hf;
        end
        wr(32'(i * 4), wd, s, r, rs);
        if (s[0]) sel[2*i] = wd[4:0];
        if (s[1]) sel[2*i+1] = wd[12:8];
        check("bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
        check("small_bresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
        rd(32'(i * 4), d, ds, r, rs);
        check("readback", exp_reg(i), d);
        check("small_read", 32'h0, ds);
        check("rresp", {30'h0, `RESP_OKAY}, {30'h0, r});
        check("small_rresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
        pin_check();
    end
    // unmapped and unaligned places must leave the selectors alone
    wr(32'h0000_0014, 32'hffff_ffff, 4'hf, r, rs);
    check("bresp_unmapped", {30'h0, `RESP_DECERR}, {30'h0, r});
    wr(32'h0000_0002, 32'hffff_ffff, 4'hf, r, rs);
    check("bresp_unaligned", {30'h0, `RESP_DECERR}, {30'h0, r});
    rd(32'h0000_0014, d, ds, r, rs);
    check("rresp_unmapped", {30'h0, `RESP_DECERR}, {30'h0, r});
    check("rdata_unmapped", 32'h0, d);
    for (i = 0; i < 5; i++)
    begin
        rd(32'(i * 4), d, ds, r, rs);
        check("kept_value", exp_reg(i), d);
    end
    @(negedge aclk);
    pd = pin_drive;
    @(posedge aclk);
    ce <= 1'b0;
    periph_out <= ~periph_out;
    @(negedge aclk);
    check("awready_ce_low", 32'h0, {31'h0, rsp.awready});
    @(posedge aclk);
    ce <= 1'b1;
    // the edge just passed saw ce low, so the pins must not have moved
    @(negedge aclk);
    check("pin_frozen", {22'h0, pd}, {22'h0, pin_drive});
    pin_check();
    print_verdict();
end
endmodule
